//--- hw/rwm_mode_ctrl.sv
// Run/wait mode controller: boot mode, vector fetch, wait entry/exit, debug gating.
// Assumes a memory that answers reads in the cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module rwm_mode_ctrl
   import rwm_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   input  wire logic        I_MODE_SEL,
   input  wire logic        I_WAIT_EXEC,
   input  wire logic        I_IRQ,
   input  wire logic        I_DBG_CMD_VALID,
   input  wire logic [7:0]  I_DBG_CMD,
   input  wire logic        I_STOP_MODE,
   input  wire logic [7:0]  I_MEM_RDATA,
   output logic             O_MEM_RD,
   output logic [15:0]      O_MEM_ADDR,
   output logic [15:0]      O_PC,
   output logic             O_PC_LOAD,
   output logic             O_CPU_CLK_EN,
   output logic             O_IMASK_CLR,
   output logic             O_STACK_START,
   output logic             O_DEBUG_ACTIVE,
   output logic             O_RUN_MODE,
   output logic             O_IN_WAIT,
   output logic             O_DBG_RESP_VALID,
   output logic [1:0]       O_DBG_RESP,
   output logic [7:0]       O_DBG_STATUS,
   output logic             O_DBG_MEM_GO
);
   // ***************************************************************
   // Mode state machine
   // ***************************************************************
   rwm_state_type state_r, state_nxt;
   logic          booted_r;
   logic [7:0]    vec_hi_r;
   logic          imask_clr_r;
   logic          stack_r;
   logic          low_pwr;
   logic          is_halt, is_stat;

   assign low_pwr = (state_r == RWM_ST_WAIT) || I_STOP_MODE;
   assign is_halt = I_DBG_CMD == RWM_CMD_HALT;
   assign is_stat = (I_DBG_CMD == RWM_CMD_RD_STAT) || (I_DBG_CMD == RWM_CMD_WR_STAT);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         RWM_ST_RESET:  begin
            // Strap caught on the first edge after release
            if (I_MODE_SEL) state_nxt = RWM_ST_VEC_HI;
            else state_nxt = RWM_ST_DEBUG;
         end
         RWM_ST_VEC_HI: state_nxt = RWM_ST_VEC_LO;
         RWM_ST_VEC_LO: state_nxt = RWM_ST_RUN;
         RWM_ST_RUN:    begin
            if (I_WAIT_EXEC) state_nxt = RWM_ST_WAIT;
         end
         RWM_ST_WAIT:   begin
            // Halt has priority over a simultaneous interrupt
            if (I_DBG_CMD_VALID && is_halt) state_nxt = RWM_ST_DEBUG;
            else if (I_IRQ) state_nxt = RWM_ST_WAKE;
         end
         RWM_ST_WAKE:   state_nxt = RWM_ST_RUN;
         RWM_ST_DEBUG:  state_nxt = RWM_ST_DEBUG;
         default:       state_nxt = RWM_ST_RESET;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) state_r <= RWM_ST_RESET;
      else state_r <= state_nxt;
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) booted_r <= 1'b0;
      else if (state_r == RWM_ST_RESET) booted_r <= I_MODE_SEL;
   end

   // ***************************************************************
   // Reset vector fetch
   // ***************************************************************
   // High byte parked until the low byte lands a cycle later
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) vec_hi_r <= 8'h00;
      else if (state_r == RWM_ST_VEC_LO) vec_hi_r <= I_MEM_RDATA;
   end

   // Low byte arrives the cycle after its request, during first RUN cycle
   logic lo_pending_r;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) lo_pending_r <= 1'b0;
      else lo_pending_r <= (state_r == RWM_ST_VEC_LO);
   end

   assign O_MEM_RD   = (state_r == RWM_ST_VEC_HI) || (state_r == RWM_ST_VEC_LO);
   assign O_MEM_ADDR = (state_r == RWM_ST_VEC_LO) ? RWM_VEC_LO_ADDR : RWM_VEC_HI_ADDR;

   logic [15:0] pc_out_r;
   logic        pc_out_ld_r;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         pc_out_r    <= 16'h0000;
         pc_out_ld_r <= 1'b0;
      end else begin
         pc_out_ld_r <= lo_pending_r;
         if (lo_pending_r) pc_out_r <= {vec_hi_r, I_MEM_RDATA};
      end
   end
   assign O_PC      = pc_out_r;
   assign O_PC_LOAD = pc_out_ld_r;

   // ***************************************************************
   // Wait entry and exit strobes
   // ***************************************************************
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         imask_clr_r <= 1'b0;
         stack_r     <= 1'b0;
      end else begin
         imask_clr_r <= (state_r == RWM_ST_RUN) && I_WAIT_EXEC;
         stack_r     <= (state_r == RWM_ST_WAKE);
      end
   end
   assign O_IMASK_CLR   = imask_clr_r;
   assign O_STACK_START = stack_r;
   // Clock is back in WAKE, one cycle ahead of the stacking strobe
   assign O_CPU_CLK_EN  = (state_r == RWM_ST_RUN) || (state_r == RWM_ST_WAKE);
   assign O_DEBUG_ACTIVE = state_r == RWM_ST_DEBUG;
   assign O_RUN_MODE     = booted_r;
   assign O_IN_WAIT      = state_r == RWM_ST_WAIT;

   // ***************************************************************
   // Debug command filter
   // ***************************************************************
   logic       resp_v_r;
   logic [1:0] resp_r;
   logic [7:0] stat_r;
   logic       go_r;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         resp_v_r <= 1'b0;
         resp_r   <= RWM_RESP_ACCEPT;
         stat_r   <= RWM_STAT_OK;
         go_r     <= 1'b0;
      end else begin
         resp_v_r <= I_DBG_CMD_VALID;
         go_r     <= 1'b0;
         if (I_DBG_CMD_VALID) begin
            stat_r <= RWM_STAT_OK;
            resp_r <= RWM_RESP_ACCEPT;
            if (low_pwr && is_stat) begin
               resp_r <= RWM_RESP_ERROR;
               stat_r <= RWM_STAT_LOWPWR;
            end else if ((state_r == RWM_ST_WAIT) && !is_halt) begin
               resp_r <= RWM_RESP_REJECT;
            end else begin
               go_r <= !is_halt;
            end
         end
      end
   end
   assign O_DBG_RESP_VALID = resp_v_r;
   assign O_DBG_RESP       = resp_r;
   assign O_DBG_STATUS     = stat_r;
   assign O_DBG_MEM_GO     = go_r;

   // ***************************************************************
   // Checks
   // ***************************************************************
   boot_run_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (state_r == RWM_ST_RESET && I_MODE_SEL) |=> state_r == RWM_ST_VEC_HI)
      else $error("Mode select high did not start run boot");
   boot_debug_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (state_r == RWM_ST_RESET && !I_MODE_SEL) |=> O_DEBUG_ACTIVE && !O_RUN_MODE)
      else $error("Mode select low did not halt in debug");
   vec_fetch_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (state_r == RWM_ST_VEC_HI) |-> O_MEM_ADDR == RWM_VEC_HI_ADDR ##1 O_MEM_ADDR == RWM_VEC_LO_ADDR
      ##2 (O_PC_LOAD && O_PC == {$past(I_MEM_RDATA, 2), $past(I_MEM_RDATA)}))
      else $error("Reset vector not loaded from top bytes");
   wait_entry_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (state_r == RWM_ST_RUN && I_WAIT_EXEC) |=> O_IN_WAIT && O_IMASK_CLR)
      else $error("Wait instruction did not enter wait");
   clk_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_IN_WAIT |-> !O_CPU_CLK_EN)
      else $error("CPU clock running in wait");
   wait_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (O_IN_WAIT && !I_IRQ && !(I_DBG_CMD_VALID && is_halt)) |=> O_IN_WAIT)
      else $error("Wait left without a wake event");
   mask_entry_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_IMASK_CLR |-> O_IN_WAIT)
      else $error("Interrupt mask cleared outside wait entry");
   wake_irq_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (O_IN_WAIT && I_IRQ && !(I_DBG_CMD_VALID && is_halt)) |=> O_CPU_CLK_EN ##1 O_STACK_START)
      else $error("Interrupt did not wake into stacking");
   wake_run_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_STACK_START |-> O_CPU_CLK_EN && !O_IN_WAIT)
      else $error("Stacking started while still waiting");
   clk_first_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_STACK_START |-> $past(O_CPU_CLK_EN))
      else $error("Stacking began before clock restored");
   // Every command gets an answer one cycle later, refused or not
   resp_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      I_DBG_CMD_VALID |=> O_DBG_RESP_VALID)
      else $error("Debug command left unanswered");
   cmd_reject_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (O_IN_WAIT && I_DBG_CMD_VALID && !is_halt && !is_stat) |=> O_DBG_RESP == RWM_RESP_REJECT && !O_DBG_MEM_GO)
      else $error("Debug command accepted in wait");
   stat_err_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (low_pwr && I_DBG_CMD_VALID && is_stat) |=> O_DBG_STATUS == RWM_STAT_LOWPWR && !O_DBG_MEM_GO)
      else $error("Status command accessed memory in low power");
   stat_ok_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (state_r == RWM_ST_RUN && !I_STOP_MODE && I_DBG_CMD_VALID && is_stat)
      |=> O_DBG_RESP == RWM_RESP_ACCEPT && O_DBG_MEM_GO)
      else $error("Status command refused in run");
   halt_debug_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (O_IN_WAIT && I_DBG_CMD_VALID && is_halt) |=> O_DEBUG_ACTIVE && !O_IN_WAIT)
      else $error("Halt in wait did not enter debug");
   halt_no_go_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (O_IN_WAIT && I_DBG_CMD_VALID && is_halt) |=> O_DBG_RESP == RWM_RESP_ACCEPT && !O_DBG_MEM_GO)
      else $error("Halt in wait not accepted");
   debug_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_DEBUG_ACTIVE |=> O_DEBUG_ACTIVE)
      else $error("Debug state left without reset");
endmodule : rwm_mode_ctrl
`default_nettype wire

//--- hw/rwm_pkg.sv
// Constants and types for the run/wait mode controller.
// Assumes a single 125 MHz clock and an active-low asynchronous reset.
// Function
// - Mode-select high at reset release: run mode
// - Start at vector from top bytes
// - Wait instruction enters wait mode
// - CPU clock gated off in wait
// - Interrupt mask cleared on wait entry
// - Interrupt wakes CPU into stacking sequence
// - Wait rejects every command except halt and status commands
// - Status commands in low power return error
// - Halt command in wait enters debug
package rwm_pkg;
   // ***************************************************************
   // Memory map
   // ***************************************************************
   localparam logic [15:0] RWM_VEC_HI_ADDR = 16'hfffe;
   localparam logic [15:0] RWM_VEC_LO_ADDR = 16'hffff;

   // ***************************************************************
   // Debug commands and status
   // ***************************************************************
   localparam logic [7:0] RWM_CMD_HALT      = 8'h90;
   localparam logic [7:0] RWM_CMD_RD_STAT   = 8'he1;
   localparam logic [7:0] RWM_CMD_WR_STAT   = 8'hc1;
   localparam logic [7:0] RWM_STAT_LOWPWR   = 8'hc0;
   localparam logic [7:0] RWM_STAT_OK       = 8'h00;
   localparam logic [1:0] RWM_RESP_ACCEPT   = 2'h0;
   localparam logic [1:0] RWM_RESP_REJECT   = 2'h1;
   localparam logic [1:0] RWM_RESP_ERROR    = 2'h2;

   typedef enum logic [2:0] {
      RWM_ST_RESET  = 3'b000,
      RWM_ST_VEC_HI = 3'b001,
      RWM_ST_VEC_LO = 3'b010,
      RWM_ST_RUN    = 3'b011,
      RWM_ST_WAIT   = 3'b100,
      RWM_ST_WAKE   = 3'b101,
      RWM_ST_DEBUG  = 3'b110
   } rwm_state_type;
endpackage : rwm_pkg

//--- tb/rwm_mem_model.sv
// Memory model that answers the reset-vector fetch.
// Assumes reads are answered on the clock after the request.
`timescale 1ns/1ps
`default_nettype none
module rwm_mem_model (
   input  wire logic        i_clk,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_vec,
   output logic      [7:0]  o_rdata
);
   // ************************************
   // Read port
   // ************************************
   initial o_rdata = 8'h5a;
   // Toggles when idle, so a late sample never matches by luck
   always @(posedge i_clk) begin
      if (i_rd && i_addr == 16'hfffe) o_rdata <= i_vec[15:8];
      else if (i_rd && i_addr == 16'hffff) o_rdata <= i_vec[7:0];
      else o_rdata <= ~o_rdata;
   end
endmodule : rwm_mem_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the run/wait mode controller.
// Assumes rwm_mem_model as memory and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rwm_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, mode_sel = 1'b1, wait_exec = 1'b0, irq = 1'b0, dv = 1'b0, stop = 1'b0;
   logic [7:0]  dc = 8'h00, rdata, status;
   logic [15:0] vec = 16'h0000, addr, pc;
   logic [1:0]  resp;
   logic        mem_rd, pc_load, clk_en, imask_clr, stack_start, dbg_act, run_mode, in_wait, resp_v, mem_go;
   int          num_errors = 0, tests_run = 0, in_w = 0;
   integer      seed = 32'h8dea4339;

   rwm_mode_ctrl i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_MODE_SEL(mode_sel), .I_WAIT_EXEC(wait_exec),
      .I_IRQ(irq), .I_DBG_CMD_VALID(dv), .I_DBG_CMD(dc), .I_STOP_MODE(stop), .I_MEM_RDATA(rdata),
      .O_MEM_RD(mem_rd), .O_MEM_ADDR(addr), .O_PC(pc), .O_PC_LOAD(pc_load), .O_CPU_CLK_EN(clk_en),
      .O_IMASK_CLR(imask_clr), .O_STACK_START(stack_start), .O_DEBUG_ACTIVE(dbg_act), .O_RUN_MODE(run_mode),
      .O_IN_WAIT(in_wait), .O_DBG_RESP_VALID(resp_v), .O_DBG_RESP(resp), .O_DBG_STATUS(status),
      .O_DBG_MEM_GO(mem_go));
   rwm_mem_model i_mem (.i_clk(clk), .i_rd(mem_rd), .i_addr(addr), .i_vec(vec), .o_rdata(rdata));

   initial forever #4 clk = ~clk;

   // ************************************
   // Checking and closing
   // ************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         num_errors++;
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // ************************************
   // Stimulus tasks
   // ************************************
   task automatic boot(input logic ms);
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      mode_sel <= ms;
      vec <= 16'($random(seed));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      in_w = 0;
      repeat (2) @(posedge clk);
      #1;
      chk(16'(run_mode), 16'(ms));
      n = 0;
      while (ms && pc_load !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 8) begin
         num_errors++;
         tally_and_finish();
      end
      if (ms) chk(pc, vec);
      else chk(16'(dbg_act), 16'h1);
      $display("test boot %0d done", ms);
   endtask : boot

   // Reference model of the debug command gate
   task automatic cmd(input logic [7:0] c, input logic with_irq);
      logic       st;
      logic [1:0] r;
      @(posedge clk);
      // Decide after the edge, once levels set by the caller have landed
      st = (c == RWM_CMD_RD_STAT || c == RWM_CMD_WR_STAT);
      r = (st && (in_w != 0 || stop)) ? RWM_RESP_ERROR :
          (in_w != 0 && c != RWM_CMD_HALT) ? RWM_RESP_REJECT : RWM_RESP_ACCEPT;
      dv <= 1'b1;
      dc <= c;
      irq <= with_irq;
      @(posedge clk);
      dv <= 1'b0;
      irq <= 1'b0;
      #1;
      chk(16'(resp_v), 16'h1);
      chk(16'(resp), 16'(r));
      chk(16'(status), (r == RWM_RESP_ERROR) ? 16'(RWM_STAT_LOWPWR) : 16'h0);
      chk(16'(mem_go), 16'(r == RWM_RESP_ACCEPT && c != RWM_CMD_HALT));
      if (in_w != 0 && c == RWM_CMD_HALT) begin
         in_w = 0;
         chk(16'({dbg_act, in_wait}), 16'h2);
      end
   endtask : cmd

   task automatic enter_wait;
      @(posedge clk);
      wait_exec <= 1'b1;
      @(posedge clk);
      wait_exec <= 1'b0;
      #1;
      in_w = 1;
      chk(16'(in_wait), 16'h1);
      chk(16'(imask_clr), 16'h1);
      chk(16'(clk_en), 16'h0);
   endtask : enter_wait

   function automatic logic [7:0] other_code;
      logic [7:0] v;
      do v = 8'($random(seed));
      while (v == RWM_CMD_HALT || v == RWM_CMD_RD_STAT || v == RWM_CMD_WR_STAT);
      return v;
   endfunction : other_code

   // ************************************
   // Main sequence
   // ************************************
   initial begin
      boot(1'b1);
      cmd(RWM_CMD_RD_STAT, 1'b0);
      cmd(RWM_CMD_WR_STAT, 1'b0);
      cmd(RWM_CMD_HALT, 1'b0);
      @(posedge clk);
      stop <= 1'b1;
      cmd(RWM_CMD_WR_STAT, 1'b0);
      @(posedge clk);
      stop <= 1'b0;
      enter_wait();
      cmd(RWM_CMD_RD_STAT, 1'b0);
      cmd(RWM_CMD_WR_STAT, 1'b0);
      repeat (4) cmd(other_code(), 1'b0);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      #1;
      chk(16'({clk_en, stack_start}), 16'h2);
      @(posedge clk);
      #1;
      in_w = 0;
      chk(16'({stack_start, in_wait}), 16'h2);
      $display("test wait wake done");
      enter_wait();
      // Interrupt raised with the halt: halt must still win
      cmd(RWM_CMD_HALT, 1'b1);
      $display("test halt priority done");
      boot(1'b0);
      cmd(other_code(), 1'b0);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
